/* File: wdtpor_map.svh */
// register offsets, field positions, reset values and timing counts of the watchdog block
// assumes inclusion by the watchdog package only
`ifndef WDTPOR_MAP_SVH
`define WDTPOR_MAP_SVH
`define WDTPOR_MODE_BANK 4'hF
`define WDTPOR_MODE_OFFSET 8'h0F
`define WDTPOR_MODE_RESET 5'h0D
`define WDTPOR_TSEL_LSB 0
`define WDTPOR_HALT_RUN_BIT 2
`define WDTPOR_STOP_RUN_BIT 3
`define WDTPOR_XTAL_SRC_BIT 4
`define WDTPOR_WARM_BIT 5
`define WDTPOR_CFG_WINDOW_CYC 60
`define WDTPOR_TOUT_XTAL_0 13'd256
`define WDTPOR_TOUT_XTAL_1 13'd512
`define WDTPOR_TOUT_XTAL_2 13'd1024
`define WDTPOR_TOUT_XTAL_3 13'd4096
`define WDTPOR_TOUT_RC_MS_0 5
`define WDTPOR_TOUT_RC_MS_1 15
`define WDTPOR_TOUT_RC_MS_2 25
`define WDTPOR_TOUT_RC_MS_3 100
`define WDTPOR_RC_TICKS_PER_MS 13'd32
`define WDTPOR_BYPASS_HOLD_CLKS 3'd5
`define WDTPOR_POR_HOLD_TICKS 13'd64
`endif

/* File: wdtpor_pkg.sv */
// types shared by the watchdog and power-up hold timer
// assumes the map header sits in the same folder
`include "wdtpor_map.svh"
package wdtpor_pkg;
    typedef enum logic [1:0] {
        wdtpor_run,
        wdtpor_halt,
        wdtpor_stop
    } wdtpor_cpu_mode_e;
    typedef enum logic [1:0] {
        wdtpor_idle,
        wdtpor_hold,
        wdtpor_release
    } wdtpor_por_state_e;
    typedef logic [12:0] wdtpor_count_t;
endpackage : wdtpor_pkg

/* File: wdtpor_tb_top.sv */
// self-checking bench for the watchdog and power-up hold timer
// assumes the watchdog package and map header compiled first
`timescale 1ns/10ps
module wdtpor_tb_top;
    import wdtpor_pkg::*;
    logic core_clk, resetn, cold_start, xtal_tick, rc_tick, por_rc_tick;
    logic first_instr, refresh_exec, reg_wr, stop_recover, recover_por_en;
    logic [3:0] reg_bank;
    logic [7:0] reg_addr, reg_wdata;
    wdtpor_cpu_mode_e cpu_mode;
    logic cpu_reset_ff, full_reset_ff, port_reset_ff, warm_start_ff;
    logic [2:0] flags_out_ff;
    logic flags_wr_ff, wdt_enabled_ff, cfg_locked_ff;
    int mismatches = 0;
    int total_checks = 0;

    wdtpor_watchdog u_dut (.core_clk(core_clk), .resetn(resetn), .cold_start(cold_start),
        .xtal_tick(xtal_tick), .rc_tick(rc_tick), .por_rc_tick(por_rc_tick),
        .cpu_mode(cpu_mode), .first_instr(first_instr), .refresh_exec(refresh_exec),
        .always_on(1'b0), .reg_wr(reg_wr), .reg_bank(reg_bank), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .stop_recover(stop_recover), .recover_por_en(recover_por_en),
        .flags_in(3'b110), .cpu_reset_ff(cpu_reset_ff), .full_reset_ff(full_reset_ff),
        .port_reset_ff(port_reset_ff), .warm_start_ff(warm_start_ff),
        .flags_out_ff(flags_out_ff), .flags_wr_ff(flags_wr_ff),
        .wdt_enabled_ff(wdt_enabled_ff), .cfg_locked_ff(cfg_locked_ff));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task give_verdict;
        if (mismatches == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    // one-cycle pulse on the chosen strobe
    task pulse(input int which);
        @(posedge core_clk);
        if (which == 0) first_instr <= 1'b1;
        else if (which == 1) refresh_exec <= 1'b1;
        else cold_start <= 1'b1;
        @(posedge core_clk);
        first_instr <= 1'b0;
        refresh_exec <= 1'b0;
        cold_start <= 1'b0;
    endtask : pulse

    task wr(input logic [3:0] bank, input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_bank <= bank;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // n consecutive tick cycles on the selected oscillator enables
    task ticks(input int n, input logic x, input logic r);
        repeat (n) begin
            @(posedge core_clk);
            xtal_tick <= x;
            rc_tick <= r;
        end
        @(posedge core_clk);
        xtal_tick <= 1'b0;
        rc_tick <= 1'b0;
    endtask : ticks

    // feed hold oscillator until the processor is let go
    task release_hold;
        int i;
        i = 0;
        @(posedge core_clk);
        por_rc_tick <= 1'b1;
        while (cpu_reset_ff !== 1'b0 && i < 400) begin
            @(posedge core_clk);
            i++;
        end
        por_rc_tick <= 1'b0;
        check("hold_len_ok", {7'h00, i >= 64 && i < 400}, 8'h01);
        cyc(2);
    endtask : release_hold

    task refresh_chk;
        logic seen;
        logic [2:0] fl;
        seen = 1'b0;
        fl = 3'h0;
        pulse(1);
        repeat (3) begin
            #1;
            if (flags_wr_ff === 1'b1) begin
                seen = 1'b1;
                fl = flags_out_ff;
            end
            @(posedge core_clk);
        end
        check("flags_wr", {7'h00, seen}, 8'h01);
        check("flags_out", {5'h00, fl}, 8'h01);
        check("wdt_enabled", {7'h00, wdt_enabled_ff}, 8'h01);
    endtask : refresh_chk

    // timeout expected exactly after n ticks counted from a refresh
    task expect_tout(input int n, input logic x, input logic r);
        ticks(n - 1, x, r);
        cyc(2);
        check("no_early_reset", {7'h00, cpu_reset_ff}, 8'h00);
        ticks(1, x, r);
        cyc(2);
        check("tout_reset", {7'h00, cpu_reset_ff}, 8'h01);
    endtask : expect_tout

    initial begin
        resetn = 1'b0;
        cold_start = 1'b0;
        xtal_tick = 1'b0;
        rc_tick = 1'b0;
        por_rc_tick = 1'b0;
        cpu_mode = wdtpor_run;
        first_instr = 1'b0;
        refresh_exec = 1'b0;
        reg_wr = 1'b0;
        stop_recover = 1'b0;
        recover_por_en = 1'b0;
        reg_bank = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        cyc(10);
        check("rst_cpu_reset", {7'h00, cpu_reset_ff}, 8'h01);
        check("rst_warm", {7'h00, warm_start_ff}, 8'h00);
        resetn <= 1'b1;
        release_hold();
        check("idle_enabled", {7'h00, wdt_enabled_ff}, 8'h00);
        // crystal clock, 256 periods, halt stop, reserved bits set
        pulse(0);
        wr(4'hF, 8'h0F, 8'hF8);
        wr(4'h0, 8'h0F, 8'h03);
        cyc(62);
        check("cfg_locked", {7'h00, cfg_locked_ff}, 8'h01);
        wr(4'hF, 8'h0F, 8'h07);
        refresh_chk();
        ticks(200, 1'b1, 1'b0);
        refresh_chk();
        cpu_mode <= wdtpor_halt;
        ticks(300, 1'b1, 1'b0);
        cyc(2);
        check("halt_no_count", {7'h00, cpu_reset_ff}, 8'h00);
        cpu_mode <= wdtpor_run;
        expect_tout(256, 1'b1, 1'b0);
        check("tout_full", {7'h00, full_reset_ff}, 8'h01);
        check("tout_port", {7'h00, port_reset_ff}, 8'h01);
        check("tout_warm", {7'h00, warm_start_ff}, 8'h01);
        release_hold();
        // cold start reloads defaults: RC source, code 01
        pulse(2);
        cyc(2);
        check("cold_warm", {7'h00, warm_start_ff}, 8'h00);
        check("cold_full", {7'h00, full_reset_ff}, 8'h01);
        release_hold();
        refresh_chk();
        expect_tout(15 * 32, 1'b1, 1'b1);
        check("rc_tout_warm", {7'h00, warm_start_ff}, 8'h01);
        release_hold();
        // stop recovery with hold timer selected
        @(posedge core_clk);
        stop_recover <= 1'b1;
        recover_por_en <= 1'b1;
        cyc(3);
        check("rec_hold", {7'h00, cpu_reset_ff}, 8'h01);
        @(posedge core_clk);
        stop_recover <= 1'b0;
        recover_por_en <= 1'b0;
        release_hold();
        // bypassed recovery: reset after 5 crystal clocks
        @(posedge core_clk);
        stop_recover <= 1'b1;
        ticks(4, 1'b1, 1'b0);
        cyc(0);
        check("byp_early", {7'h00, cpu_reset_ff}, 8'h00);
        ticks(1, 1'b1, 1'b0);
        cyc(0);
        check("byp_reset", {7'h00, cpu_reset_ff}, 8'h01);
        @(posedge core_clk);
        stop_recover <= 1'b0;
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        give_verdict();
    end
endmodule : wdtpor_tb_top

/* File: wdtpor_watchdog.sv */
// watchdog with write-once mode register and power-up hold one-shot timer
// assumes core_clk at 25 MHz, synchronous inputs, one-cycle tick enables from the oscillators
//
// Operation
// - unrefreshed terminal count resets the processor
// - run or halt timeout equals power-up reset
// - first refresh enables, later refreshes restart
// - enabled watchdog cleared only by cold start
// - refresh updates zero, sign, overflow flags
// - mode writes only in first 60 cycles
// - mode register write-only at bank F 0Fh
// - crystal timeouts 256, 512, 1024, 4096 periods
// - RC timeouts 5, 15, 25, 100 ms
// - time select resets to code 01
// - bit 2 keeps counting in halt
// - halt timeout restores control and port defaults
// - bit 3 keeps counting in stop
// - bits 3 and 4 clock watchdog in stop; the logic gates stop counting on bit 3 alone, bit 4 only picks the source
// - stop timeout resets ports like stop recovery
// - bit 4 selects crystal or RC chain clock
// - power-up hold after cold, recovery, timeout
// - bypassed recovery needs 5 crystal clocks held
// - cold start clears warm-start bit, full reset
// - mode reset selects 15 ms, halt, stop, RC
`timescale 1ns/10ps
module wdtpor_watchdog
    import wdtpor_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cold_start,
    input wire logic xtal_tick,
    input wire logic rc_tick,
    input wire logic por_rc_tick,
    input wire wdtpor_cpu_mode_e cpu_mode,
    input wire logic first_instr,
    input wire logic refresh_exec,
    input wire logic always_on,
    input wire logic reg_wr,
    input wire logic [3:0] reg_bank,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic stop_recover,
    input wire logic recover_por_en,
    input wire logic [2:0] flags_in,
    output logic cpu_reset_ff,
    output logic full_reset_ff,
    output logic port_reset_ff,
    output logic warm_start_ff,
    output logic [2:0] flags_out_ff,
    output logic flags_wr_ff,
    output logic wdt_enabled_ff,
    output logic cfg_locked_ff
);
    logic [4:0] mode_ff;
    logic [5:0] win_cnt_ff;
    logic win_open_ff;
    wdtpor_count_t wdt_cnt_ff;
    wdtpor_count_t por_cnt_ff;
    wdtpor_por_state_e por_state_ff;
    logic [2:0] byp_cnt_ff;
    logic timeout;
    logic tick;
    logic count_ok;
    logic mode_wr;
    logic por_busy;
    wdtpor_count_t limit;

    function automatic wdtpor_count_t tout_limit(input logic [1:0] tsel, input logic xtal);
        wdtpor_count_t v;
        v = `WDTPOR_TOUT_XTAL_0;
        if (xtal) begin
            case (tsel)
                2'h0: v = `WDTPOR_TOUT_XTAL_0;
                2'h1: v = `WDTPOR_TOUT_XTAL_1;
                2'h2: v = `WDTPOR_TOUT_XTAL_2;
                default: v = `WDTPOR_TOUT_XTAL_3;
            endcase
        end else begin
            case (tsel)
                2'h0: v = 13'(`WDTPOR_TOUT_RC_MS_0 * `WDTPOR_RC_TICKS_PER_MS);
                2'h1: v = 13'(`WDTPOR_TOUT_RC_MS_1 * `WDTPOR_RC_TICKS_PER_MS);
                2'h2: v = 13'(`WDTPOR_TOUT_RC_MS_2 * `WDTPOR_RC_TICKS_PER_MS);
                default: v = 13'(`WDTPOR_TOUT_RC_MS_3 * `WDTPOR_RC_TICKS_PER_MS);
            endcase
        end
        return v;
    endfunction : tout_limit

    // write decode, reserved bits dropped
    assign mode_wr = reg_wr && win_open_ff && (reg_bank == `WDTPOR_MODE_BANK)
        && (reg_addr == `WDTPOR_MODE_OFFSET);

    // 60-cycle write window opened by the first instruction
    always_ff @(posedge core_clk) begin
        if (!resetn || cpu_reset_ff) begin
            win_cnt_ff <= 6'h00;
            win_open_ff <= 1'b0;
            cfg_locked_ff <= 1'b0;
        end else if (first_instr && !cfg_locked_ff) begin
            win_cnt_ff <= 6'h00;
            win_open_ff <= 1'b1;
        end else if (win_open_ff) begin
            if (win_cnt_ff == 6'(`WDTPOR_CFG_WINDOW_CYC - 1)) begin
                win_open_ff <= 1'b0;
                cfg_locked_ff <= 1'b1;
            end
            win_cnt_ff <= win_cnt_ff + 6'h01;
        end
    end

    // mode register, reset only by full reset or cold start
    always_ff @(posedge core_clk) begin
        if (!resetn || cold_start) begin
            mode_ff <= `WDTPOR_MODE_RESET;
        end else if (mode_wr) begin
            mode_ff <= reg_wdata[4:0];
        end
    end

    // clock and gating selection
    always_comb begin
        tick = mode_ff[`WDTPOR_XTAL_SRC_BIT] ? xtal_tick : rc_tick;
        case (cpu_mode)
            wdtpor_halt: count_ok = mode_ff[`WDTPOR_HALT_RUN_BIT];
            wdtpor_stop: begin
                count_ok = mode_ff[`WDTPOR_STOP_RUN_BIT];
            end
            default: count_ok = 1'b1;
        endcase
        limit = tout_limit(mode_ff[1:0], mode_ff[`WDTPOR_XTAL_SRC_BIT]);
    end

    assign timeout = wdt_enabled_ff && tick && count_ok && !por_busy
        && (wdt_cnt_ff >= limit - 13'd1);

    // enable latch, only a cold start can clear it
    always_ff @(posedge core_clk) begin
        if (!resetn || cold_start) begin
            wdt_enabled_ff <= 1'b0;
        end else if (always_on || refresh_exec) begin
            wdt_enabled_ff <= 1'b1;
        end
    end

    // timeout counter
    always_ff @(posedge core_clk) begin
        if (!resetn || cold_start || refresh_exec || timeout || por_busy) begin
            wdt_cnt_ff <= 13'h0000;
        end else if (wdt_enabled_ff && tick && count_ok) begin
            wdt_cnt_ff <= wdt_cnt_ff + 13'h0001;
        end
    end

    // flag update for refresh
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            flags_out_ff <= 3'h0;
            flags_wr_ff <= 1'b0;
        end else begin
            flags_wr_ff <= refresh_exec;
            flags_out_ff <= refresh_exec ? {1'b0, 1'b0, 1'b1} : flags_in;
        end
    end

    // power-up hold one-shot
    assign por_busy = (por_state_ff != wdtpor_idle);
    always_ff @(posedge core_clk) begin
        if (!resetn || cold_start) begin
            por_state_ff <= wdtpor_hold;
            por_cnt_ff <= 13'h0000;
        end else begin
            case (por_state_ff)
                wdtpor_idle: begin
                    if (timeout || (stop_recover && recover_por_en)) begin
                        por_state_ff <= wdtpor_hold;
                        por_cnt_ff <= 13'h0000;
                    end
                end
                wdtpor_hold: begin
                    if (por_rc_tick) begin
                        por_cnt_ff <= por_cnt_ff + 13'h0001;
                        if (por_cnt_ff == `WDTPOR_POR_HOLD_TICKS - 13'd1) begin
                            por_state_ff <= wdtpor_release;
                        end
                    end
                end
                default: por_state_ff <= wdtpor_idle;
            endcase
        end
    end

    // bypassed recovery: source held 5 crystal clocks
    always_ff @(posedge core_clk) begin
        if (!resetn || !stop_recover || recover_por_en) begin
            byp_cnt_ff <= 3'h0;
        end else if (xtal_tick && byp_cnt_ff != `WDTPOR_BYPASS_HOLD_CLKS) begin
            byp_cnt_ff <= byp_cnt_ff + 3'h1;
        end
    end

    // reset outputs
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cpu_reset_ff <= 1'b1;
            full_reset_ff <= 1'b1;
            port_reset_ff <= 1'b1;
            warm_start_ff <= 1'b0;
        end else begin
            cpu_reset_ff <= por_busy || timeout || cold_start
                || (byp_cnt_ff == `WDTPOR_BYPASS_HOLD_CLKS - 3'd1 && xtal_tick);
            if (cold_start) begin
                full_reset_ff <= 1'b1;
                port_reset_ff <= 1'b1;
                warm_start_ff <= 1'b0;
            end else if (timeout) begin
                full_reset_ff <= (cpu_mode != wdtpor_stop);
                port_reset_ff <= 1'b1;
                warm_start_ff <= 1'b1;
            end else if (!por_busy) begin
                full_reset_ff <= 1'b0;
                port_reset_ff <= 1'b0;
            end
        end
    end

    property p_lock_after_window;
        @(posedge core_clk) disable iff (!resetn)
        cfg_locked_ff && !cpu_reset_ff && !cold_start |=> $stable(mode_ff);
    endproperty
    a_lock_after_window: assert property (p_lock_after_window)
        else $error("mode changed after lock");

    property p_stays_enabled;
        @(posedge core_clk) disable iff (!resetn)
        wdt_enabled_ff && !cold_start |=> wdt_enabled_ff;
    endproperty
    a_stays_enabled: assert property (p_stays_enabled)
        else $error("watchdog disabled");

    property p_refresh_clears;
        @(posedge core_clk) disable iff (!resetn)
        refresh_exec |=> wdt_cnt_ff == 13'h0000;
    endproperty
    a_refresh_clears: assert property (p_refresh_clears)
        else $error("refresh did not clear count");

    property p_timeout_resets;
        @(posedge core_clk) disable iff (!resetn)
        timeout |=> cpu_reset_ff && port_reset_ff;
    endproperty
    a_timeout_resets: assert property (p_timeout_resets)
        else $error("timeout without reset");

    property p_run_full;
        @(posedge core_clk) disable iff (!resetn)
        timeout && cpu_mode != wdtpor_stop && !cold_start |=> full_reset_ff;
    endproperty
    a_run_full: assert property (p_run_full)
        else $error("run timeout not full reset");

    property p_stop_partial;
        @(posedge core_clk) disable iff (!resetn)
        timeout && cpu_mode == wdtpor_stop && !cold_start |=> !full_reset_ff;
    endproperty
    a_stop_partial: assert property (p_stop_partial)
        else $error("stop timeout did full reset");

    property p_cold_warm;
        @(posedge core_clk) disable iff (!resetn)
        cold_start |=> !warm_start_ff && full_reset_ff && mode_ff == `WDTPOR_MODE_RESET;
    endproperty
    a_cold_warm: assert property (p_cold_warm)
        else $error("cold start not applied");

    property p_flags;
        @(posedge core_clk) disable iff (!resetn)
        refresh_exec |=> flags_wr_ff;
    endproperty
    a_flags: assert property (p_flags)
        else $error("refresh did not write flags");

    property p_halt_frozen;
        @(posedge core_clk) disable iff (!resetn)
        cpu_mode == wdtpor_halt && !mode_ff[`WDTPOR_HALT_RUN_BIT] && !refresh_exec
            && !por_busy && !cold_start |=> $stable(wdt_cnt_ff);
    endproperty
    a_halt_frozen: assert property (p_halt_frozen)
        else $error("count moved in halt");

    sequence s_recover_req;
        stop_recover && recover_por_en && por_state_ff == wdtpor_idle && !timeout;
    endsequence
    property p_recover_hold;
        @(posedge core_clk) disable iff (!resetn || cold_start)
        s_recover_req |=> por_state_ff == wdtpor_hold ##1 cpu_reset_ff;
    endproperty
    a_recover_hold: assert property (p_recover_hold)
        else $error("recovery hold not started");
endmodule : wdtpor_watchdog
